// [verilog/pbcg_pkg.sv]
// Constants for the peripheral bus clock gating register block.
// Assumes one system clock and a plain single-cycle register port.
package pbcg_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] FAST_EN_OFFSET = 8'h18;
    localparam logic [7:0] SLOW_EN_OFFSET = 8'h1C;
    localparam logic [31:0] FAST_EN_RESET = 32'h0000_0000;
    localparam logic [31:0] SLOW_EN_RESET = 32'h0000_0000;
    // Implemented bits; every other position reads zero.
    localparam logic [31:0] FAST_EN_MASK = 32'h0000_FFFD;
    localparam logic [31:0] SLOW_EN_MASK = 32'h3EFE_C83F;

    // ****************************************************************
    // Faster bus enable bit positions
    // ****************************************************************
    localparam int ALT_FUNC_IO_CLK_EN = 0;
    localparam int PORT_A_CLK_EN = 2;
    localparam int PORT_B_CLK_EN = 3;
    localparam int PORT_C_CLK_EN = 4;
    localparam int PORT_D_CLK_EN = 5;
    localparam int PORT_E_CLK_EN = 6;
    localparam int PORT_F_CLK_EN = 7;
    localparam int PORT_G_CLK_EN = 8;
    localparam int ANALOG_CONV1_CLK_EN = 9;
    localparam int ANALOG_CONV2_CLK_EN = 10;
    localparam int ADV_TIMER_ONE_CLK_EN = 11;
    localparam int SERIAL_PERIPH_ONE_CLK_EN = 12;
    localparam int ADV_TIMER_EIGHT_CLK_EN = 13;
    localparam int SYNC_ASYNC_SERIAL_ONE_CLK_EN = 14;
    localparam int ANALOG_CONV3_CLK_EN = 15;

    // ****************************************************************
    // Slower bus enable bit positions
    // ****************************************************************
    localparam int GP_TIMER_TWO_CLK_EN = 0;
    localparam int GP_TIMER_THREE_CLK_EN = 1;
    localparam int GP_TIMER_FOUR_CLK_EN = 2;
    localparam int GP_TIMER_FIVE_CLK_EN = 3;
    localparam int BASIC_TIMER_SIX_CLK_EN = 4;
    localparam int BASIC_TIMER_SEVEN_CLK_EN = 5;
    localparam int WINDOW_WATCHDOG_CLK_EN = 11;
    localparam int SERIAL_PERIPH_TWO_CLK_EN = 14;
    localparam int SERIAL_PERIPH_THREE_CLK_EN = 15;
    localparam int SYNC_ASYNC_SERIAL_TWO_CLK_EN = 17;
    localparam int SYNC_ASYNC_SERIAL_THREE_CLK_EN = 18;
    localparam int ASYNC_SERIAL_FOUR_CLK_EN = 19;
    localparam int ASYNC_SERIAL_FIVE_CLK_EN = 20;
    localparam int TWO_WIRE_A_CLK_EN = 21;
    localparam int TWO_WIRE_B_CLK_EN = 22;
    localparam int USB_DEVICE_CLK_EN = 23;
    localparam int CTRL_NET_ONE_CLK_EN = 25;
    localparam int CTRL_NET_TWO_CLK_EN = 26;
    localparam int BACKUP_IF_CLK_EN = 27;
    localparam int POWER_IF_CLK_EN = 28;
    localparam int DAC_IF_CLK_EN = 29;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Merges the enabled byte lanes of a write into the old value.
    function automatic logic [31:0] pbcg_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] be,
        input logic [31:0] mask
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction : pbcg_merge

endpackage : pbcg_pkg

// [verilog/pbcg_regs.sv]
// Peripheral clock enable registers for the faster and slower buses,
// with glitch-free clock gates and read gating of peripheral data.
// Assumes a single system clock and that the master holds off new
// strobes while bus_wait is high.
//
// Operation
// - Slower-bus enable register at 0x1C, resets to zero.
// - Both registers accept word, half-word and byte accesses.
// - Faster-bus register access waits while a faster-bus access runs.
// - Slower-bus register access waits while a slower-bus access runs.
// - Reads of a peripheral with clock disabled return zero.
// - Every implemented bit is writable; 1 enables, 0 disables.
// - Faster bit 0 enables the alternate-function I/O clock.
// - Faster bits 2 to 8 enable ports A to G.
// - Faster bits 9, 10, 15 enable converters 1, 2, 3.
// - Faster bit 11 enables timer 1, bit 13 timer 8.
// - Faster bit 12 enables serial interface 1, bit 14 serial port 1.
// - Slower bits 0 to 5 enable timers 2 to 7.
// - Slower bit 11 enables the window watchdog clock.
// - Slower bits 14, 15 enable serial interfaces 2, 3.
// - Slower bits 17 to 20 enable serial ports 2 to 5.
// - Slower bit 21 enables two-wire 1/3, bit 22 two-wire 2/4.
// - Slower bit 23 enables both USB device instances.
// - Slower bits 25, 26 enable network controllers 1, 2.
// - Slower bit 28 enables power interface, bit 29 DAC.
module pbcg_regs
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic [pbcg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pbcg_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [3:0] reg_be,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pbcg_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    output logic bus_wait,
    // Peripheral bus activity
    input wire logic fast_busy,
    input wire logic slow_busy,
    // Peripheral read gating
    input wire logic [3:0] fast_rd_sel,
    input wire logic [31:0] fast_rd_data,
    output logic [31:0] fast_rd_data_g,
    input wire logic [4:0] slow_rd_sel,
    input wire logic [31:0] slow_rd_data,
    output logic [31:0] slow_rd_data_g,
    // Enables and gated clocks
    output logic [15:0] fast_clk_en,
    output logic [31:0] slow_clk_en,
    output logic [15:0] fast_gclk,
    output logic [31:0] slow_gclk
);
    import pbcg_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [31:0] fast_en;
        logic [31:0] slow_en;
        logic pend;
        logic pend_wr;
        logic [7:0] pend_addr;
        logic [31:0] pend_wdata;
        logic [3:0] pend_be;
        logic [31:0] rdata;
        logic rvalid;
        logic [31:0] fast_g;
        logic [31:0] slow_g;
    } pbcg_state_s;

    pbcg_state_s st_r;
    pbcg_state_s st_nxt;

    logic new_req;
    logic new_fast;
    logic new_slow;
    logic pend_fast;
    logic pend_slow;
    logic go;
    logic go_wr;
    logic [7:0] go_addr;
    logic [31:0] go_wdata;
    logic [3:0] go_be;

    // ****************************************************************
    // Access sequencing
    // ****************************************************************
    // An access that meets a busy bus is parked and finished once the
    // bus goes idle; the register port has room for only one parked
    // access, so the master must respect bus_wait.
    always_comb
    begin
        new_req = (reg_wr | reg_rd) & ~st_r.pend;
        new_fast = reg_addr == FAST_EN_OFFSET;
        new_slow = reg_addr == SLOW_EN_OFFSET;
        pend_fast = st_r.pend_addr == FAST_EN_OFFSET;
        pend_slow = st_r.pend_addr == SLOW_EN_OFFSET;
        go = 1'b0;
        go_wr = reg_wr;
        go_addr = reg_addr;
        go_wdata = reg_wdata;
        go_be = reg_be;
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        if (st_r.pend)
        begin
            go_wr = st_r.pend_wr;
            go_addr = st_r.pend_addr;
            go_wdata = st_r.pend_wdata;
            go_be = st_r.pend_be;
            if (!(pend_fast && fast_busy) && !(pend_slow && slow_busy))
            begin
                go = 1'b1;
                st_nxt.pend = 1'b0;
            end
        end
        else if (new_req)
        begin
            if ((new_fast && fast_busy) || (new_slow && slow_busy))
            begin
                st_nxt.pend = 1'b1;
                st_nxt.pend_wr = reg_wr;
                st_nxt.pend_addr = reg_addr;
                st_nxt.pend_wdata = reg_wdata;
                st_nxt.pend_be = reg_be;
            end
            else
            begin
                go = 1'b1;
            end
        end
        if (go && go_wr)
        begin
            if (go_addr == FAST_EN_OFFSET)
            begin
                st_nxt.fast_en = pbcg_merge(st_r.fast_en, go_wdata,
                    go_be, FAST_EN_MASK);
            end
            if (go_addr == SLOW_EN_OFFSET)
            begin
                st_nxt.slow_en = pbcg_merge(st_r.slow_en, go_wdata,
                    go_be, SLOW_EN_MASK);
            end
        end
        if (go && !go_wr)
        begin
            st_nxt.rvalid = 1'b1;
            // Unmapped offsets read as zero.
            unique case (go_addr)
                FAST_EN_OFFSET: st_nxt.rdata = st_r.fast_en;
                SLOW_EN_OFFSET: st_nxt.rdata = st_r.slow_en;
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        // A peripheral without its clock must not leak stale contents.
        st_nxt.fast_g = st_r.fast_en[fast_rd_sel] ?
            fast_rd_data : 32'h0000_0000;
        st_nxt.slow_g = st_r.slow_en[slow_rd_sel] ?
            slow_rd_data : 32'h0000_0000;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r <= '{fast_en: FAST_EN_RESET, slow_en: SLOW_EN_RESET,
                default: '0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Clock gates
    // ****************************************************************
    // The enable is caught while the clock is low, so a change made
    // mid-cycle can never chop a high phase short.
    logic [15:0] fast_lat;
    logic [31:0] slow_lat;

    always_latch
    begin
        if (!clock)
        begin
            fast_lat = st_r.fast_en[15:0];
            slow_lat = st_r.slow_en;
        end
    end

    assign fast_gclk = fast_lat & {16{clock}};
    assign slow_gclk = slow_lat & {32{clock}};

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign fast_clk_en = st_r.fast_en[15:0];
    assign slow_clk_en = st_r.slow_en;
    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign bus_wait = st_r.pend;
    assign fast_rd_data_g = st_r.fast_g;
    assign slow_rd_data_g = st_r.slow_g;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    a_slow_write_lands: assert property (
        reg_wr && !st_r.pend && reg_addr == SLOW_EN_OFFSET &&
        reg_be == 4'hF && !slow_busy
        |=> slow_clk_en == ($past(reg_wdata) & SLOW_EN_MASK))
        else $error("slow enable write not stored");

    a_byte_lane_keep: assert property (
        reg_wr && !st_r.pend && reg_addr == FAST_EN_OFFSET &&
        reg_be == 4'h1 && !fast_busy
        |=> fast_clk_en[15:8] == $past(fast_clk_en[15:8]) &&
        fast_clk_en[7:0] == ($past(reg_wdata[7:0]) & 8'hFD))
        else $error("byte write touched wrong lane");

    a_fast_wait_hold: assert property (
        (reg_wr || reg_rd) && !st_r.pend &&
        reg_addr == FAST_EN_OFFSET && fast_busy
        |=> bus_wait && fast_clk_en == $past(fast_clk_en))
        else $error("fast access not held while bus busy");

    a_slow_wait_hold: assert property (
        bus_wait && pend_slow && slow_busy |=> bus_wait)
        else $error("slow access released while bus busy");

    a_wait_release: assert property (
        bus_wait && pend_slow && !slow_busy |=> !bus_wait)
        else $error("slow access not released when bus idle");

    a_gated_read_zero: assert property (
        !fast_clk_en[fast_rd_sel] |=> fast_rd_data_g == 32'h0000_0000)
        else $error("disabled peripheral read leaked data");

    a_slow_gated_zero: assert property (
        !slow_clk_en[slow_rd_sel] |=> slow_rd_data_g == 32'h0000_0000)
        else $error("disabled slow peripheral read leaked data");

    a_reserved_zero: assert property (
        (st_r.fast_en & ~FAST_EN_MASK) == 32'h0000_0000 &&
        (slow_clk_en & ~SLOW_EN_MASK) == 32'h0000_0000)
        else $error("reserved enable bit set");

    a_read_back: assert property (
        reg_rd && !st_r.pend && reg_addr == SLOW_EN_OFFSET && !slow_busy
        |=> reg_rvalid && reg_rdata == $past(slow_clk_en))
        else $error("slow enable read back wrong");

    a_gate_latch: assert property (
        fast_lat == fast_clk_en && slow_lat == slow_clk_en)
        else $error("clock gate latch lags its enable");

    c_fast_write: cover property (
        reg_wr && reg_addr == FAST_EN_OFFSET && !fast_busy);
    c_slow_parked: cover property (
        bus_wait && pend_slow ##1 !bus_wait);
    c_gated_read: cover property (
        slow_clk_en[slow_rd_sel] && slow_rd_data != 32'h0000_0000);
    c_half_write: cover property (
        reg_wr && reg_be == 4'hC && reg_addr == SLOW_EN_OFFSET);

endmodule : pbcg_regs

// [tb/pbcg_regs_tb_top.sv]
// Self-checking bench for the peripheral clock enable registers.
// Assumes the register block has no parameters and one system clock.
module pbcg_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import pbcg_pkg::*;

    // ****************************************************************
    // Signals and instance
    // ****************************************************************
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [3:0] reg_be = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_rvalid;
    logic bus_wait;
    logic fast_busy = 1'b0;
    logic slow_busy = 1'b0;
    logic [3:0] fast_rd_sel = 4'h0;
    logic [31:0] fast_rd_data = 32'hA5A5_A5A5;
    logic [31:0] fast_rd_data_g;
    logic [4:0] slow_rd_sel = 5'h00;
    logic [31:0] slow_rd_data = 32'h5A5A_5A5A;
    logic [31:0] slow_rd_data_g;
    logic [15:0] fast_clk_en;
    logic [31:0] slow_clk_en;
    logic [15:0] fast_gclk;
    logic [31:0] slow_gclk;
    int error_cnt = 0;
    int n_tests = 0;
    int lat;
    logic [31:0] rd_v;

    always #5 clock = ~clock;

    pbcg_regs pbcg_regs_inst (.clock(clock), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .bus_wait(bus_wait),
        .fast_busy(fast_busy), .slow_busy(slow_busy),
        .fast_rd_sel(fast_rd_sel), .fast_rd_data(fast_rd_data),
        .fast_rd_data_g(fast_rd_data_g), .slow_rd_sel(slow_rd_sel),
        .slow_rd_data(slow_rd_data), .slow_rd_data_g(slow_rd_data_g),
        .fast_clk_en(fast_clk_en), .slow_clk_en(slow_clk_en),
        .fast_gclk(fast_gclk), .slow_gclk(slow_gclk));

    // ****************************************************************
    // Bus tasks and comparison
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        reg_be <= be;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
        for (int k = 0; k < 40 && bus_wait === 1'b1; k++)
        begin
            @(posedge clock);
            #1;
        end
    endtask : wr

    // Returns the data and the number of cycles beyond the normal one.
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output int l);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        l = 0;
        while (reg_rvalid !== 1'b1 && l < 40)
        begin
            @(posedge clock);
            #1;
            l++;
        end
        d = reg_rdata;
    endtask : rd

    function automatic logic [31:0] en_of(input logic [7:0] a);
        return (a == FAST_EN_OFFSET) ? {16'h0, fast_clk_en} : slow_clk_en;
    endfunction : en_of

    function automatic logic [31:0] gclk_of(input logic [7:0] a);
        return (a == FAST_EN_OFFSET) ? {16'h0, fast_gclk} : slow_gclk;
    endfunction : gclk_of

    // Walks a single one through every bit and checks store and gates.
    task automatic walk(input logic [7:0] a, input logic [31:0] m);
        logic [31:0] e;
        for (int i = 0; i < 32; i++)
        begin
            e = (32'h1 << i) & m;
            wr(a, 32'h1 << i, 4'hF);
            chk("enable out", e, en_of(a));
            rd(a, rd_v, lat);
            chk("readback", e, rd_v);
            @(posedge clock);
            #2;
            chk("gclk high", e, gclk_of(a));
            @(negedge clock);
            #2;
            chk("gclk low", 32'h0, gclk_of(a));
        end
    endtask : walk

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial
    begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        chk("fast reset", FAST_EN_RESET, {16'h0, fast_clk_en});
        rd(SLOW_EN_OFFSET, rd_v, lat);
        chk("slow reset", SLOW_EN_RESET, rd_v);
        chk("no wait", 32'h0, lat);
        $display("test reset done");
        // Bit positions are tagged in the package; the walk hits each.
        walk(FAST_EN_OFFSET, FAST_EN_MASK);
        walk(SLOW_EN_OFFSET, SLOW_EN_MASK);
        // The walks end on a reserved bit, so both registers read zero.
        wr(FAST_EN_OFFSET, 32'h1 << ADV_TIMER_ONE_CLK_EN, 4'hF);
        wr(SLOW_EN_OFFSET, 32'h1 << DAC_IF_CLK_EN, 4'hF);
        chk("timer1", 32'h1, fast_clk_en[ADV_TIMER_ONE_CLK_EN]);
        chk("dac", 32'h1, slow_clk_en[DAC_IF_CLK_EN]);
        $display("test walk done");
        wr(SLOW_EN_OFFSET, 32'h0, 4'hF);
        wr(SLOW_EN_OFFSET, 32'hFFFF_FFFF, 4'b0100);
        chk("slow byte", 32'h00FE_0000, slow_clk_en);
        wr(SLOW_EN_OFFSET, 32'hFFFF_FFFF, 4'b1100);
        chk("slow half", 32'h3EFE_0000, slow_clk_en);
        wr(FAST_EN_OFFSET, 32'h0000_ABCD, 4'b0011);
        wr(FAST_EN_OFFSET, 32'h0000_00FF, 4'b0001);
        wr(FAST_EN_OFFSET, 32'hFFFF_0000, 4'b1100);
        rd(FAST_EN_OFFSET, rd_v, lat);
        chk("fast lanes", 32'h0000_ABFD, rd_v);
        chk("fast no wait", 32'h0, lat);
        wr(8'h20, 32'hFFFF_FFFF, 4'hF);
        rd(8'h20, rd_v, lat);
        chk("unmapped", 32'h0, rd_v);
        chk("slow kept", 32'h3EFE_0000, slow_clk_en);
        $display("test lanes done");
        // A busy fast bus stalls only the fast register.
        @(posedge clock);
        fast_busy <= 1'b1;
        rd(SLOW_EN_OFFSET, rd_v, lat);
        chk("slow not parked", 32'h0, lat);
        fork
            rd(FAST_EN_OFFSET, rd_v, lat);
            begin
                repeat (3) @(posedge clock);
                #1;
                chk("parked wait", 32'h1, bus_wait);
                chk("parked rvalid", 32'h0, reg_rvalid);
                @(posedge clock);
                fast_busy <= 1'b0;
                @(posedge clock);
                #1;
                chk("released", 32'h1, reg_rvalid & ~bus_wait);
            end
        join
        chk("parked data", 32'h0000_ABFD, rd_v);
        chk("parked cycles", 32'h3, lat);
        @(posedge clock);
        slow_busy <= 1'b1;
        fork
            wr(SLOW_EN_OFFSET, 32'h0000_0800, 4'hF);
            begin
                repeat (4) @(posedge clock);
                #1;
                chk("write parked", 32'h3EFE_0000, slow_clk_en);
                @(posedge clock);
                slow_busy <= 1'b0;
            end
        join
        chk("write done", 32'h0000_0800, slow_clk_en);
        $display("test wait done");
        wr(FAST_EN_OFFSET, 32'h1 << PORT_B_CLK_EN, 4'hF);
        @(posedge clock);
        fast_rd_sel <= 4'(PORT_B_CLK_EN);
        slow_rd_sel <= 5'(WINDOW_WATCHDOG_CLK_EN);
        repeat (2) @(posedge clock);
        #1;
        chk("fast gated on", 32'hA5A5_A5A5, fast_rd_data_g);
        chk("slow gated on", 32'h5A5A_5A5A, slow_rd_data_g);
        @(posedge clock);
        fast_rd_sel <= 4'(PORT_C_CLK_EN);
        slow_rd_sel <= 5'(BACKUP_IF_CLK_EN);
        repeat (2) @(posedge clock);
        #1;
        chk("fast gated off", 32'h0, fast_rd_data_g);
        chk("slow gated off", 32'h0, slow_rd_data_g);
        $display("test read gating done");
        report_and_stop();
    end

    initial
    begin
        #200000;
        error_cnt++;
        report_and_stop();
    end
endmodule : pbcg_regs_tb_top
